// ---- rtl/sai_pkg.sv ----
package sai_pkg;

  // Global register window
  localparam logic [11:0] GLOBAL_BASE = 12'h0f0;
  localparam logic [11:0] GLOBAL_LAST = 12'h0ff;

  // Host-visible offsets
  localparam logic [11:0] OFF_TXQ     = 12'h010;
  localparam logic [11:0] OFF_TXPKT   = 12'h011;
  localparam logic [11:0] OFF_RXPKT   = 12'h012;
  localparam logic [11:0] OFF_LAPS    = 12'h013;
  localparam logic [11:0] OFF_RXQ     = 12'h020;
  localparam logic [11:0] OFF_PRBS    = 12'h030;
  localparam logic [11:0] OFF_GSTAT   = 12'h0f4;
  localparam logic [11:0] OFF_GENABLE = 12'h0f5;

  // Receive queue latched layout
  localparam int RXQ_HIGH = 0;
  localparam int RXQ_LOW  = 1;
  localparam int RXQ_OVF  = 2;
  localparam int RXQ_FIFO = 3;
  // Receive queue enable layout (differs from latched)
  localparam int RXQ_EN_LOW  = 0;
  localparam int RXQ_EN_HIGH = 1;
  localparam int RXQ_EN_FIFO = 2;
  localparam int RXQ_EN_OVF  = 3;

  // Header check bits
  localparam int LAPS_ADDR      = 0;
  localparam int LAPS_CTRL      = 1;
  localparam int LAPS_SAPI_LOW  = 2;
  localparam int LAPS_SAPI_HIGH = 3;

  // Implemented bits per latched register
  localparam logic [7:0] MASK_TXQ   = 8'h0f;
  localparam logic [7:0] MASK_TXPKT = 8'h01;
  localparam logic [7:0] MASK_RXPKT = 8'hff;
  localparam logic [7:0] MASK_LAPS  = 8'h0f;
  localparam logic [7:0] MASK_RXQ   = 8'h0f;
  localparam logic [7:0] MASK_PRBS  = 8'h0f;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Reset recovery time
  localparam int CLK_PERIOD_NS     = 4;
  localparam int RESET_RECOVERY_NS = 5000000;
  localparam int RESET_RECOVERY_CYCLES = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CNT_W = 21;

  typedef enum logic [1:0] {REC_WAIT, REC_COUNT, REC_READY} sai_rec_e;

  typedef struct packed {
    logic [3:0] txq;
    logic       txpkt;
    logic [7:0] rxpkt;
    logic [3:0] rxq;
    logic [3:0] prbs;
  } sai_events_s;

  typedef struct packed {
    logic [7:0] address;
    logic [7:0] control;
    logic [7:0] sapi_high;
    logic [7:0] sapi_low;
  } sai_laps_hdr_s;

  typedef struct packed {
    logic [3:0] txq;
    logic       txpkt;
    logic [7:0] rxpkt;
    logic [3:0] laps;
    logic [3:0] rxq;
    logic [3:0] prbs;
  } sai_enables_s;

  // Bit 0 line, 1 system, 2 prbs, 3 queue
  typedef struct packed {
    logic queue;
    logic prbs;
    logic system;
    logic line;
  } sai_global_s;

endpackage

// ---- rtl/sai_latch8.sv ----
`timescale 1ns/1ns
`default_nettype none
module sai_latch8 #(
  parameter logic [7:0] IMPL_MASK = 8'hff
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clr_all,
  input  wire logic [7:0] set_bits,
  input  wire logic       wr_one_clr,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_clr,
  output logic      [7:0] bits
);

  typedef struct packed {
    logic [7:0] bits;
  } sai_latch_s;

  sai_latch_s state;
  sai_latch_s next_state;

  always_comb begin
    next_state = state;
    if (clr_all) begin
      next_state.bits = sai_pkg::RESET_BYTE;
    end else begin
      if (rd_clr) begin
        next_state.bits = sai_pkg::RESET_BYTE;
      end
      if (wr_one_clr) begin
        next_state.bits = next_state.bits & ~wr_data;
      end
      // New events beat a same-cycle read or write-one clear, not clr_all; set regardless of enables
      next_state.bits = next_state.bits | set_bits;
    end
    next_state.bits = next_state.bits & IMPL_MASK;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bits = state.bits;

endmodule
`default_nettype wire

// ---- rtl/sai_irq_pin.sv ----
`timescale 1ns/1ns
`default_nettype none
module sai_irq_pin (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                hold_off,
  input  wire sai_pkg::sai_global_s gstat,
  input  wire sai_pkg::sai_global_s genable,
  input  wire logic                idle_drive,
  output logic                     irq_n_out,
  output logic                     irq_n_oe,
  output logic                     irq_active
);

  typedef struct packed {
    logic asserted;
    logic drive_idle;
  } sai_pin_s;

  sai_pin_s state;
  sai_pin_s next_state;

  always_comb begin
    next_state            = state;
    next_state.drive_idle = idle_drive;
    if (hold_off) begin
      next_state.asserted = 1'b0;
    end else begin
      next_state.asserted = |(gstat & genable);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Active low; when idle, either released for a pull-up or driven high
  assign irq_n_out  = ~state.asserted;
  assign irq_n_oe   = state.asserted | state.drive_idle;
  assign irq_active = state.asserted;

endmodule
`default_nettype wire

// ---- rtl/sai_aggregator.sv ----
`timescale 1ns/1ns
`default_nettype none
module sai_aggregator #(
  parameter int RESET_RECOVERY_CYCLES = sai_pkg::RESET_RECOVERY_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  global_reset_bit,
  input  wire logic                  serial_reset_bit,
  input  wire sai_pkg::sai_events_s  events,
  input  wire logic                  laps_hdr_valid,
  input  wire sai_pkg::sai_laps_hdr_s laps_hdr,
  input  wire sai_pkg::sai_laps_hdr_s expected_laps,
  input  wire sai_pkg::sai_enables_s irq_enables,
  input  wire sai_pkg::sai_global_s  global_enables,
  input  wire logic                  irq_idle_drive_select,
  input  wire logic [11:0]           host_addr,
  input  wire logic                  host_rd,
  input  wire logic                  host_wr,
  input  wire logic [7:0]            host_wdata,
  output logic      [7:0]            host_rdata,
  output logic                       host_rvalid,
  output sai_pkg::sai_global_s       global_status,
  output logic      [7:0]            tx_queue_latched_status,
  output logic      [7:0]            tx_packet_latched_status,
  output logic      [7:0]            rx_packet_latched_status,
  output logic      [7:0]            rx_laps_header_status,
  output logic      [7:0]            rx_queue_latched_status,
  output logic      [7:0]            prbs_latched_status,
  output logic                       irq_n_out,
  output logic                       irq_n_oe,
  output logic                       irq_active,
  output logic                       reset_recovery_done
);

  typedef struct packed {
    logic [7:0]                rdata;
    logic                      rvalid;
    sai_pkg::sai_global_s      gstat;
    sai_pkg::sai_rec_e         rec;
    logic [sai_pkg::REC_CNT_W-1:0] rec_cnt;
  } sai_top_s;

  localparam int REC_CNT_W = sai_pkg::REC_CNT_W;

  sai_top_s state;
  sai_top_s next_state;

  // Decoding used by every latched register
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic in_global(input logic [11:0] addr);
    in_global = (addr >= sai_pkg::GLOBAL_BASE) && (addr <= sai_pkg::GLOBAL_LAST);
  endfunction

  // Reorders receive queue enables into the latched layout
  function automatic logic [7:0] rxq_enable_map(input logic [3:0] en);
    logic [7:0] m;
    m = 8'h00;
    m[sai_pkg::RXQ_HIGH] = en[sai_pkg::RXQ_EN_HIGH];
    m[sai_pkg::RXQ_LOW]  = en[sai_pkg::RXQ_EN_LOW];
    m[sai_pkg::RXQ_OVF]  = en[sai_pkg::RXQ_EN_OVF];
    m[sai_pkg::RXQ_FIFO] = en[sai_pkg::RXQ_EN_FIFO];
    rxq_enable_map = m;
  endfunction

  logic       in_reset;
  logic       line_reset;
  logic [7:0] set_txq;
  logic [7:0] set_txpkt;
  logic [7:0] set_rxpkt;
  logic [7:0] set_laps;
  logic [7:0] set_rxq;
  logic [7:0] set_prbs;
  logic [5:0] wr_sel;
  logic [5:0] rd_sel;
  logic [7:0] en_txq;
  logic [7:0] en_txpkt;
  logic [7:0] en_rxpkt;
  logic [7:0] en_laps;
  logic [7:0] en_rxq;
  logic [7:0] en_prbs;
  logic       txq_pending;
  logic       txpkt_pending;
  logic       rxpkt_pending;
  logic       laps_pending;
  logic       rxq_pending;
  logic       prbs_pending;
  sai_pkg::sai_global_s live_gstat;

  // Software reset acts like the pin; serial reset hits line-side status only
  assign in_reset   = global_reset_bit;
  assign line_reset = global_reset_bit | serial_reset_bit;

  assign set_txq   = {4'h0, events.txq};
  assign set_txpkt = {7'h00, events.txpkt};
  assign set_rxpkt = events.rxpkt;
  assign set_rxq   = {4'h0, events.rxq};
  assign set_prbs  = {4'h0, events.prbs};

  always_comb begin
    set_laps = 8'h00;
    if (laps_hdr_valid) begin
      set_laps[sai_pkg::LAPS_ADDR]      = laps_hdr.address != expected_laps.address;
      set_laps[sai_pkg::LAPS_CTRL]      = laps_hdr.control != expected_laps.control;
      set_laps[sai_pkg::LAPS_SAPI_LOW]  = laps_hdr.sapi_low != expected_laps.sapi_low;
      set_laps[sai_pkg::LAPS_SAPI_HIGH] = laps_hdr.sapi_high != expected_laps.sapi_high;
    end
  end

  // Host strobes per latched register; order txq, txpkt, rxpkt, laps, rxq, prbs
  always_comb begin
    wr_sel = {hit(host_addr, sai_pkg::OFF_PRBS), hit(host_addr, sai_pkg::OFF_RXQ),
              hit(host_addr, sai_pkg::OFF_LAPS), hit(host_addr, sai_pkg::OFF_RXPKT),
              hit(host_addr, sai_pkg::OFF_TXPKT), hit(host_addr, sai_pkg::OFF_TXQ)};
    rd_sel = wr_sel & {6{host_rd}};
    wr_sel = wr_sel & {6{host_wr}};
  end

  sai_latch8 #(.IMPL_MASK(sai_pkg::MASK_TXQ)) u_txq (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clr_all    (line_reset),
    .set_bits   (set_txq),
    .wr_one_clr (wr_sel[0]),
    .wr_data    (host_wdata),
    .rd_clr     (rd_sel[0]),
    .bits       (tx_queue_latched_status)
  );

  sai_latch8 #(.IMPL_MASK(sai_pkg::MASK_TXPKT)) u_txpkt (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clr_all    (line_reset),
    .set_bits   (set_txpkt),
    .wr_one_clr (wr_sel[1]),
    .wr_data    (host_wdata),
    .rd_clr     (rd_sel[1]),
    .bits       (tx_packet_latched_status)
  );

  sai_latch8 #(.IMPL_MASK(sai_pkg::MASK_RXPKT)) u_rxpkt (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clr_all    (line_reset),
    .set_bits   (set_rxpkt),
    .wr_one_clr (wr_sel[2]),
    .wr_data    (host_wdata),
    .rd_clr     (rd_sel[2]),
    .bits       (rx_packet_latched_status)
  );

  sai_latch8 #(.IMPL_MASK(sai_pkg::MASK_LAPS)) u_laps (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clr_all    (line_reset),
    .set_bits   (set_laps),
    .wr_one_clr (wr_sel[3]),
    .wr_data    (host_wdata),
    .rd_clr     (rd_sel[3]),
    .bits       (rx_laps_header_status)
  );

  sai_latch8 #(.IMPL_MASK(sai_pkg::MASK_RXQ)) u_rxq (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clr_all    (in_reset),
    .set_bits   (set_rxq),
    .wr_one_clr (wr_sel[4]),
    .wr_data    (host_wdata),
    .rd_clr     (rd_sel[4]),
    .bits       (rx_queue_latched_status)
  );

  sai_latch8 #(.IMPL_MASK(sai_pkg::MASK_PRBS)) u_prbs (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clr_all    (in_reset),
    .set_bits   (set_prbs),
    .wr_one_clr (wr_sel[5]),
    .wr_data    (host_wdata),
    .rd_clr     (rd_sel[5]),
    .bits       (prbs_latched_status)
  );

  // Second level: enabled latched bits only
  assign en_txq   = {4'h0, irq_enables.txq};
  assign en_txpkt = {7'h00, irq_enables.txpkt};
  assign en_rxpkt = irq_enables.rxpkt;
  assign en_laps  = {4'h0, irq_enables.laps};
  assign en_rxq   = rxq_enable_map(irq_enables.rxq);
  assign en_prbs  = {4'h0, irq_enables.prbs};

  assign txq_pending   = |(tx_queue_latched_status & en_txq);
  assign txpkt_pending = |(tx_packet_latched_status & en_txpkt);
  assign rxpkt_pending = |(rx_packet_latched_status & en_rxpkt);
  assign laps_pending  = |(rx_laps_header_status & en_laps);
  assign rxq_pending   = |(rx_queue_latched_status & en_rxq);
  assign prbs_pending  = |(prbs_latched_status & en_prbs);

  always_comb begin
    live_gstat.line   = txq_pending | txpkt_pending | rxpkt_pending | laps_pending;
    live_gstat.system = rxq_pending;
    live_gstat.prbs   = prbs_pending;
    live_gstat.queue  = txpkt_pending | rxpkt_pending;
  end

  always_comb begin
    next_state        = state;
    next_state.rvalid = host_rd;
    // Recomputed every cycle, so it drops one cycle after the sources are serviced
    next_state.gstat  = in_reset ? '0 : live_gstat;
    if (host_rd) begin
      if (hit(host_addr, sai_pkg::OFF_TXQ)) begin
        next_state.rdata = tx_queue_latched_status;
      end else if (hit(host_addr, sai_pkg::OFF_TXPKT)) begin
        next_state.rdata = tx_packet_latched_status;
      end else if (hit(host_addr, sai_pkg::OFF_RXPKT)) begin
        next_state.rdata = rx_packet_latched_status;
      end else if (hit(host_addr, sai_pkg::OFF_LAPS)) begin
        next_state.rdata = rx_laps_header_status;
      end else if (hit(host_addr, sai_pkg::OFF_RXQ)) begin
        next_state.rdata = rx_queue_latched_status;
      end else if (hit(host_addr, sai_pkg::OFF_PRBS)) begin
        next_state.rdata = prbs_latched_status;
      end else if (in_global(host_addr) && hit(host_addr, sai_pkg::OFF_GSTAT)) begin
        next_state.rdata = {4'h0, state.gstat};
      end else if (in_global(host_addr) && hit(host_addr, sai_pkg::OFF_GENABLE)) begin
        next_state.rdata = {4'h0, global_enables};
      end else begin
        next_state.rdata = sai_pkg::RESET_BYTE;
      end
    end
    // Recovery timer tells the host when configuration may start
    case (state.rec)
      sai_pkg::REC_WAIT: begin
        next_state.rec_cnt = '0;
        if (!in_reset) begin
          next_state.rec = sai_pkg::REC_COUNT;
        end
      end
      sai_pkg::REC_COUNT: begin
        if (in_reset) begin
          next_state.rec = sai_pkg::REC_WAIT;
        end else if (state.rec_cnt == REC_CNT_W'(RESET_RECOVERY_CYCLES - 1)) begin
          next_state.rec = sai_pkg::REC_READY;
        end else begin
          next_state.rec_cnt = state.rec_cnt + 1'b1;
        end
      end
      sai_pkg::REC_READY: begin
        if (in_reset) begin
          next_state.rec = sai_pkg::REC_WAIT;
        end
      end
      default: begin
        next_state.rec = sai_pkg::REC_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '{rdata: 8'h00, rvalid: 1'b0, gstat: '0, rec: sai_pkg::REC_WAIT, rec_cnt: '0};
    end else begin
      state <= next_state;
    end
  end

  sai_irq_pin u_pin (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .hold_off   (in_reset),
    .gstat      (state.gstat),
    .genable    (global_enables),
    .idle_drive (irq_idle_drive_select),
    .irq_n_out  (irq_n_out),
    .irq_n_oe   (irq_n_oe),
    .irq_active (irq_active)
  );

  assign host_rdata          = state.rdata;
  assign host_rvalid         = state.rvalid;
  assign global_status       = state.gstat;
  assign reset_recovery_done = (state.rec == sai_pkg::REC_READY);

endmodule
`default_nettype wire

// ---- tb/sai_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sai_host_model (
  input  wire logic        clk,
  output logic      [11:0] host_addr,
  output logic             host_rd,
  output logic             host_wr,
  output logic      [7:0]  host_wdata
);
  initial begin
    host_addr = 12'h000;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 8'h00;
  end

  // One byte access; strobe held for exactly one edge
  task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_wr <= wr;
    host_rd <= !wr;
    host_wdata <= d;
    @(posedge clk);
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    // Stale data is not left on the bus
    host_wdata <= ~d;
    host_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ---- tb/sai_checker_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module sai_checker (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  global_reset_bit,
  input wire sai_pkg::sai_events_s  events,
  input wire sai_pkg::sai_enables_s irq_enables,
  input wire sai_pkg::sai_global_s  global_enables,
  input wire logic                  irq_idle_drive_select,
  input wire logic [11:0]           host_addr,
  input wire logic                  host_rd,
  input wire logic                  host_wr,
  input wire logic [7:0]            host_wdata,
  input wire logic                  host_rvalid,
  input wire sai_pkg::sai_global_s  global_status,
  input wire logic [7:0]            tx_packet_latched_status,
  input wire logic [7:0]            rx_packet_latched_status,
  input wire logic [7:0]            rx_queue_latched_status,
  input wire logic [7:0]            prbs_latched_status,
  input wire logic                  irq_n_out,
  input wire logic                  irq_n_oe,
  input wire logic                  irq_active
);
  logic [3:0] rxq_en;
  logic       sys_pend;
  logic       prbs_pend;
  logic       q_pend;
  logic       g_on;
  // Enable order differs from latched order
  assign rxq_en = {irq_enables.rxq[2], irq_enables.rxq[3], irq_enables.rxq[0], irq_enables.rxq[1]};
  assign sys_pend = |(rx_queue_latched_status[3:0] & rxq_en);
  assign prbs_pend = |(prbs_latched_status[3:0] & irq_enables.prbs);
  assign q_pend = (tx_packet_latched_status[0] & irq_enables.txpkt) | |(rx_packet_latched_status & irq_enables.rxpkt);
  assign g_on = |(global_status & global_enables);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_quiet;
    global_reset_bit |=> !irq_active && irq_n_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin active during global reset");
  property p_latch;
    events.prbs != 4'h0 && !global_reset_bit |=> (prbs_latched_status[3:0] & $past(events.prbs)) == $past(events.prbs);
  endproperty
  a_latch: assert property (p_latch) else $error("event not latched");
  property p_rdclr;
    host_rd && host_addr == sai_pkg::OFF_PRBS && events.prbs == 4'h0 && !global_reset_bit
      |=> host_rvalid && prbs_latched_status == 8'h00;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("read did not clear register");
  property p_wr1c;
    host_wr && host_addr == sai_pkg::OFF_RXQ && events.rxq == 4'h0
      |=> (rx_queue_latched_status & $past(host_wdata)) == 8'h00;
  endproperty
  a_wr1c: assert property (p_wr1c) else $error("write one did not clear");
  property p_sys;
    !global_reset_bit && !$past(global_reset_bit) |-> global_status.system == $past(sys_pend);
  endproperty
  a_sys: assert property (p_sys) else $error("system summary wrong");
  property p_prbs;
    !global_reset_bit && !$past(global_reset_bit) |-> global_status.prbs == $past(prbs_pend);
  endproperty
  a_prbs: assert property (p_prbs) else $error("prbs summary wrong");
  property p_queue;
    !global_reset_bit && !$past(global_reset_bit) |-> global_status.queue == $past(q_pend);
  endproperty
  a_queue: assert property (p_queue) else $error("queue summary wrong");
  property p_pin;
    !global_reset_bit && !$past(global_reset_bit) |-> irq_active == $past(g_on);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not OR of enabled summaries");
  property p_idle;
    !irq_active && !global_reset_bit && !$past(sys_rst) && $stable(irq_idle_drive_select)
      |-> irq_n_out && irq_n_oe == irq_idle_drive_select;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pin drive wrong");

  c_irq: cover property (irq_active && !irq_n_out);
  c_rdclr: cover property (host_rd && host_addr == sai_pkg::OFF_PRBS ##1 host_rvalid);
  c_drive: cover property (irq_n_oe && !irq_active);
endmodule
bind sai_aggregator sai_checker u_chk (.clk(clk), .sys_rst(sys_rst), .global_reset_bit(global_reset_bit),
  .events(events), .irq_enables(irq_enables), .global_enables(global_enables),
  .irq_idle_drive_select(irq_idle_drive_select), .host_addr(host_addr), .host_rd(host_rd),
  .host_wr(host_wr), .host_wdata(host_wdata), .host_rvalid(host_rvalid), .global_status(global_status),
  .tx_packet_latched_status(tx_packet_latched_status), .rx_packet_latched_status(rx_packet_latched_status),
  .rx_queue_latched_status(rx_queue_latched_status), .prbs_latched_status(prbs_latched_status),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_active(irq_active));
`default_nettype wire

// ---- tb/status_interrupt_aggregator_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module status_interrupt_aggregator_tb_top;
  localparam int REC = 20;
  localparam int MAP [4] = '{1, 0, 3, 2};
  localparam int LBYTE [4] = '{3, 2, 0, 1};
  localparam logic [11:0] OFFS [6] = '{12'h010, 12'h011, 12'h012, 12'h013, 12'h020, 12'h030};
  logic                   clk, sys_rst, grst, srst, laps_v, sel;
  logic                   rd, wr, rvalid, irq_n, irq_oe, irq_act, rec_done;
  logic [11:0]            addr;
  logic [7:0]             wdata, rdata, txq_seen, laps_seen;
  sai_pkg::sai_events_s   ev, e;
  sai_pkg::sai_laps_hdr_s hdr, exp_hdr;
  sai_pkg::sai_enables_s  en;
  sai_pkg::sai_global_s   gen, gstat;
  logic [7:0]             q_exp [$];
  int                     fail_count = 0;
  int                     n_checks = 0;
  int                     cycles = 0;
  int                     seed, i;

  sai_aggregator #(.RESET_RECOVERY_CYCLES(REC)) DUT (.clk(clk), .sys_rst(sys_rst), .global_reset_bit(grst),
    .serial_reset_bit(srst), .events(ev), .laps_hdr_valid(laps_v), .laps_hdr(hdr), .expected_laps(exp_hdr),
    .irq_enables(en), .global_enables(gen), .irq_idle_drive_select(sel), .host_addr(addr), .host_rd(rd),
    .host_wr(wr), .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid), .global_status(gstat),
    .tx_queue_latched_status(txq_seen), .tx_packet_latched_status(), .rx_packet_latched_status(),
    .rx_laps_header_status(laps_seen), .rx_queue_latched_status(), .prbs_latched_status(), .irq_n_out(irq_n),
    .irq_n_oe(irq_oe), .irq_active(irq_act), .reset_recovery_done(rec_done));
  sai_host_model host (.clk(clk), .host_addr(addr), .host_rd(rd), .host_wr(wr), .host_wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd_exp(input logic [11:0] a, input logic [7:0] x);
    q_exp.push_back(x);
    host.access(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input sai_pkg::sai_events_s p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= 21'h000000;
  endtask

  // Read answers are matched in issue order
  always @(negedge clk)
    if (rvalid === 1'b1)
      chk(rdata, (q_exp.size() > 0) ? q_exp.pop_front() : 8'hxx);

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    seed = 77418;
    sys_rst = 1'b1;
    grst = 1'b0;
    srst = 1'b0;
    laps_v = 1'b0;
    sel = 1'b0;
    ev = 21'h000000;
    e = 21'h000000;
    hdr = 32'h00000000;
    exp_hdr = 32'h00000000;
    en = 25'h0000000;
    gen = 4'h0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    wt(1);
    chk(irq_n, 1'b1);
    chk(irq_oe, 1'b0);
    // No configuration until the recovery time has run out
    wt(REC);
    chk(rec_done, 1'b1);
    foreach (OFFS[k]) begin
      host.access(1'b1, OFFS[k], 8'h00);
      rd_exp(OFFS[k], 8'h00);
    end
    for (i = 0; i < 4; i++)
      host.access(1'b1, 12'h10c + 12'(i), 8'hff);
    e.prbs = 4'($random(seed)) | 4'h1;
    pulse(e);
    wt(3);
    chk(irq_act, 1'b0);
    chk(gstat.prbs, 1'b0);
    rd_exp(sai_pkg::OFF_PRBS, {4'h0, e.prbs});
    rd_exp(sai_pkg::OFF_PRBS, 8'h00);
    @(posedge clk);
    en.prbs <= 4'hf;
    pulse(e);
    wt(3);
    chk(gstat.prbs, 1'b1);
    chk(irq_act, 1'b0);
    @(posedge clk);
    gen <= 4'h4;
    wt(2);
    chk(irq_n, 1'b0);
    rd_exp(sai_pkg::OFF_GSTAT, 8'h04);
    rd_exp(sai_pkg::OFF_PRBS, {4'h0, e.prbs});
    wt(3);
    chk(irq_act, 1'b0);
    @(posedge clk);
    sel <= 1'b1;
    gen <= 4'h2;
    wt(2);
    chk(irq_oe, 1'b1);
    for (i = 0; i < 4; i++) begin
      e = 21'h000000;
      e.rxq = 4'h1 << i;
      @(posedge clk);
      en.rxq <= 4'hf ^ (4'h1 << MAP[i]);
      pulse(e);
      wt(3);
      chk(irq_act, 1'b0);
      @(posedge clk);
      en.rxq <= 4'h1 << MAP[i];
      wt(3);
      chk(gstat.system, 1'b1);
      chk(irq_n, 1'b0);
      host.access(1'b1, sai_pkg::OFF_RXQ, 8'h01 << i);
      wt(3);
      chk(irq_act, 1'b0);
      rd_exp(sai_pkg::OFF_RXQ, 8'h00);
    end
    @(posedge clk);
    gen <= 4'h1;
    en.laps <= 4'hf;
    exp_hdr <= 32'($random(seed));
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      hdr <= exp_hdr ^ (32'h000000ff << (8 * LBYTE[i]));
      laps_v <= 1'b1;
      @(posedge clk);
      laps_v <= 1'b0;
      wt(3);
      chk(gstat.line, 1'b1);
      chk(laps_seen, 8'h01 << i);
      rd_exp(sai_pkg::OFF_LAPS, 8'h01 << i);
    end
    @(posedge clk);
    gen <= 4'h8;
    en.rxpkt <= 8'hff;
    en.txpkt <= 1'b1;
    e = 21'h000000;
    e.rxpkt = 8'($random(seed)) | 8'h01;
    e.txpkt = 1'b1;
    e.txq = 4'($random(seed)) | 4'h1;
    pulse(e);
    wt(3);
    chk(gstat.queue, 1'b1);
    chk(gstat.line, 1'b1);
    chk(irq_act, 1'b1);
    rd_exp(sai_pkg::OFF_RXPKT, e.rxpkt);
    rd_exp(sai_pkg::OFF_TXPKT, 8'h01);
    chk(txq_seen, {4'h0, e.txq});
    rd_exp(sai_pkg::OFF_TXQ, {4'h0, e.txq});
    rd_exp(12'h0a5, 8'h00);
    wt(3);
    chk(irq_act, 1'b0);
    pulse(e);
    wt(3);
    // Serial reset wipes the line-side registers only
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd_exp(sai_pkg::OFF_RXPKT, 8'h00);
    rd_exp(sai_pkg::OFF_TXQ, 8'h00);
    pulse(e);
    wt(3);
    @(posedge clk);
    grst <= 1'b1;
    wt(1);
    chk(irq_act, 1'b0);
    chk(irq_n, 1'b1);
    @(posedge clk);
    grst <= 1'b0;
    wt(1);
    chk(rec_done, 1'b0);
    wt(REC - 1);
    chk(rec_done, 1'b0);
    wt(1);
    chk(rec_done, 1'b1);
    rd_exp(sai_pkg::OFF_RXPKT, 8'h00);
    wt(2);
    chk(8'(q_exp.size()), 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
